// ===== hw/cix_alu.sv
// Purpose: data path for the file and accumulator operations
// Assumes: pure combinational, op already decoded
// Notes: non-data ops yield the operand unchanged
`timescale 1ns/100ps
module cix_alu (
  input  wire cix_pkg::cix_op_t          op,     // decoded operation
  input  wire logic [cix_pkg::DATA_W-1:0] fval,   // file register operand
  output logic      [cix_pkg::DATA_W-1:0] result, // operation result
  output logic                            zero    // result is zero
);
  localparam logic [cix_pkg::DATA_W-1:0] ONE = 8'h01;
  localparam logic [cix_pkg::DATA_W-1:0] NIL = 8'h00;

  always_comb begin
    case (op)
      cix_pkg::OP_ZERO_FILE_REG:    result = NIL;
      cix_pkg::OP_ZERO_ACCUMULATOR: result = NIL;
      cix_pkg::OP_INVERT_FILE_REG:  result = ~fval;
      cix_pkg::OP_REDUCE_BY_ONE:    result = fval - ONE;
      default:                      result = fval;
    endcase
    zero = (result == NIL);
  end
endmodule

// ===== hw/cix_core.sv
// Purpose: executes the instruction subset from local program memory
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes: memories, pc, acc and flags are written by the bus only while halted; latch and run at any time
`timescale 1ns/100ps
module cix_core #(
  parameter int PM_AW   = 8, // program memory address width
  parameter int STACK_D = 8, // return stack depth
  parameter int PRE_W   = 8, // watchdog prescaler width
  parameter int WDOG_W  = 8  // watchdog counter width
) (
  input  wire logic        CLK_SYS,   // system clock
  input  wire logic        RST,       // sync reset, high
  input  wire logic        HSEL,      // slave select
  input  wire logic [31:0] HADDR,     // byte address
  input  wire logic [1:0]  HTRANS,    // transfer type
  input  wire logic        HWRITE,    // write when high
  input  wire logic [2:0]  HSIZE,     // transfer size
  input  wire logic [31:0] HWDATA,    // write data
  input  wire logic        HREADY,    // bus ready
  output logic      [31:0] HRDATA,    // read data
  output logic             HREADYOUT, // slave ready
  output logic             HRESP      // response, always okay
);
  localparam int RF_D = 1 << cix_pkg::F_W;
  localparam int PM_D = 1 << PM_AW;
  localparam int SP_W = $clog2(STACK_D);
  localparam int AW = cix_pkg::ADDR_W;
  localparam int DW = cix_pkg::DATA_W;

  typedef enum logic [1:0] {ST_HALT, ST_EXEC, ST_FLUSH} cix_state_t;

  logic [DW-1:0] rf [RF_D];
  logic [cix_pkg::INSTR_W-1:0] pm [PM_D];
  logic [cix_pkg::PC_W-1:0] stk [STACK_D];

  cix_state_t state;
  cix_state_t next_state;
  logic [cix_pkg::PC_W-1:0] pc;
  logic [cix_pkg::PC_W-1:0] next_pc;
  logic [SP_W-1:0] sp;
  logic [DW-1:0] acc;
  logic [cix_pkg::LATCH_W-1:0] upper_pc_holding_latch;
  logic z_flag;
  logic watchdog_expiry_flag_n;
  logic sleep_entered_flag_n;
  logic run;
  logic [WDOG_W-1:0] watchdog_counter;

  logic [cix_pkg::INSTR_W-1:0] instr;
  cix_pkg::cix_op_t op;
  logic [cix_pkg::F_W-1:0] faddr;
  logic [cix_pkg::B_W-1:0] bsel;
  logic [cix_pkg::K_W-1:0] kval;
  logic dsel;
  logic [DW-1:0] fval;
  logic [DW-1:0] alu_res;
  logic alu_zero;
  logic exec;
  logic skip_taken;
  logic do_call;
  logic kick;
  logic wr_acc;
  logic wr_file;
  logic set_z;
  logic [cix_pkg::PC_W-1:0] stack_head;

  logic a_valid;
  logic a_write;
  logic [AW-1:0] a_addr;
  logic d_write;
  logic [AW-1:0] d_addr;
  logic halted;

  // two-bit window select of a byte address
  function automatic logic [1:0] win_of(input logic [AW-1:0] a);
    win_of = a[cix_pkg::WIN_MSB:cix_pkg::WIN_LSB];
  endfunction

  // register file index of a byte address
  function automatic logic [cix_pkg::F_W-1:0] rf_idx(input logic [AW-1:0] a);
    rf_idx = a[cix_pkg::F_W+1:2];
  endfunction

  // program memory index of a byte address
  function automatic logic [PM_AW-1:0] pm_idx(input logic [AW-1:0] a);
    pm_idx = a[PM_AW+1:2];
  endfunction

  // file window is 256 words; its upper half is a hole, not an alias
  function automatic logic rf_hit(input logic [AW-1:0] a);
    rf_hit = (win_of(a) == cix_pkg::WIN_RF) && !a[cix_pkg::F_W+2];
  endfunction

  // instruction decode
  assign instr = pm[pc[PM_AW-1:0]];
  assign op = cix_pkg::cix_op_t'(instr[cix_pkg::INSTR_W-1:cix_pkg::OP_LSB]);
  assign faddr = instr[cix_pkg::F_W-1:0];
  assign bsel = instr[cix_pkg::B_LSB+cix_pkg::B_W-1:cix_pkg::B_LSB];
  assign kval = instr[cix_pkg::K_W-1:0];
  assign dsel = instr[cix_pkg::D_BIT];
  assign fval = rf[faddr];
  assign stack_head = stk[sp - {{(SP_W-1){1'b0}}, 1'b1}];

  cix_alu u_alu (
    .op     (op),
    .fval   (fval),
    .result (alu_res),
    .zero   (alu_zero)
  );

  cix_wdog #(
    .PRE_W (PRE_W),
    .CNT_W (WDOG_W)
  ) u_wdog (
    .clk   (CLK_SYS),
    .rst   (RST),
    .clear (kick),
    .count (watchdog_counter)
  );

  assign exec = (state == ST_EXEC);
  assign halted = (state == ST_HALT);
  assign skip_taken = exec && (op == cix_pkg::OP_SKIP_ON_BIT_LOW) && !fval[bsel];
  assign do_call = exec && (op == cix_pkg::OP_CALL);
  assign kick = exec && (op == cix_pkg::OP_KICK_WATCHDOG);

  always_comb begin
    wr_acc = 1'b0;
    wr_file = 1'b0;
    set_z = 1'b0;
    if (exec) begin
      case (op)
        cix_pkg::OP_ZERO_FILE_REG: begin
          wr_file = 1'b1;
          set_z = 1'b1;
        end
        cix_pkg::OP_ZERO_ACCUMULATOR: begin
          wr_acc = 1'b1;
          set_z = 1'b1;
        end
        cix_pkg::OP_INVERT_FILE_REG, cix_pkg::OP_REDUCE_BY_ONE: begin
          wr_acc = !dsel;
          wr_file = dsel;
          set_z = 1'b1;
        end
        default: begin
          set_z = 1'b0;
        end
      endcase
    end
  end

  // sequencing: a taken skip or a call spends a second, idle cycle
  always_comb begin
    next_state = state;
    next_pc = pc;
    case (state)
      ST_HALT: begin
        if (run) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (do_call) begin
          next_pc = {upper_pc_holding_latch[cix_pkg::PCL_HI:cix_pkg::PCL_LO], kval};
          next_state = ST_FLUSH;
        end else if (skip_taken) begin
          next_pc = pc + cix_pkg::PC_TWO;
          next_state = ST_FLUSH;
        end else begin
          next_pc = pc + cix_pkg::PC_ONE;
          next_state = run ? ST_EXEC : ST_HALT;
        end
      end
      ST_FLUSH: begin
        next_state = run ? ST_EXEC : ST_HALT;
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= ST_HALT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pc <= cix_pkg::PC_RST;
    end else if (halted && d_write && d_addr == cix_pkg::A_PC) begin
      pc <= HWDATA[cix_pkg::PC_W-1:0];
    end else begin
      pc <= next_pc;
    end
  end

  // stack wraps silently when overfilled
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sp <= '0;
    end else if (do_call) begin
      sp <= sp + {{(SP_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (do_call) begin
      stk[sp] <= pc + cix_pkg::PC_ONE;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      acc <= cix_pkg::ACC_RST;
    end else if (wr_acc) begin
      acc <= alu_res;
    end else if (halted && d_write && d_addr == cix_pkg::A_ACC) begin
      acc <= HWDATA[DW-1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (wr_file) begin
      rf[faddr] <= alu_res;
    end else if (halted && d_write && rf_hit(d_addr)) begin
      rf[rf_idx(d_addr)] <= HWDATA[DW-1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (halted && d_write && win_of(d_addr) == cix_pkg::WIN_PM) begin
      pm[pm_idx(d_addr)] <= HWDATA[cix_pkg::INSTR_W-1:0];
    end
  end

  // call and skip leave the flags alone
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      z_flag <= 1'b0;
    end else if (set_z) begin
      z_flag <= alu_zero;
    end else if (halted && d_write && d_addr == cix_pkg::A_STATUS) begin
      z_flag <= HWDATA[cix_pkg::ST_Z];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      watchdog_expiry_flag_n <= 1'b1;
      sleep_entered_flag_n <= 1'b1;
    end else if (kick) begin
      watchdog_expiry_flag_n <= 1'b1;
      sleep_entered_flag_n <= 1'b1;
    end else if (halted && d_write && d_addr == cix_pkg::A_STATUS) begin
      watchdog_expiry_flag_n <= HWDATA[cix_pkg::ST_EXPIRY_N];
      sleep_entered_flag_n <= HWDATA[cix_pkg::ST_SLEEP_N];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      upper_pc_holding_latch <= cix_pkg::LATCH_RST;
    end else if (d_write && d_addr == cix_pkg::A_LATCH) begin
      upper_pc_holding_latch <= HWDATA[cix_pkg::LATCH_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      run <= 1'b0;
    end else if (d_write && d_addr == cix_pkg::A_CTRL) begin
      run <= HWDATA[0];
    end
  end

  // bus address phase
  assign a_valid = HSEL && HREADY && HTRANS[1];
  assign a_write = a_valid && HWRITE;
  assign a_addr = HADDR[AW-1:0];

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      d_write <= 1'b0;
      d_addr <= '0;
    end else begin
      d_write <= a_write;
      d_addr <= a_addr;
    end
  end

  // zero wait state; read data is captured at the address phase edge
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      HRDATA <= 32'h00000000;
    end else if (a_valid && !HWRITE) begin
      HRDATA <= 32'h00000000;
      if (rf_hit(a_addr)) begin
        HRDATA[DW-1:0] <= rf[rf_idx(a_addr)];
      end else if (win_of(a_addr) == cix_pkg::WIN_PM) begin
        HRDATA[cix_pkg::INSTR_W-1:0] <= pm[pm_idx(a_addr)];
      end else begin
        case (a_addr)
          cix_pkg::A_CTRL:   HRDATA[0] <= run;
          cix_pkg::A_STATUS: begin
            HRDATA[cix_pkg::ST_Z] <= z_flag;
            HRDATA[cix_pkg::ST_SLEEP_N] <= sleep_entered_flag_n;
            HRDATA[cix_pkg::ST_EXPIRY_N] <= watchdog_expiry_flag_n;
          end
          cix_pkg::A_PC:     HRDATA[cix_pkg::PC_W-1:0] <= pc;
          cix_pkg::A_ACC:    HRDATA[DW-1:0] <= acc;
          cix_pkg::A_LATCH:  HRDATA[cix_pkg::LATCH_W-1:0] <= upper_pc_holding_latch;
          cix_pkg::A_WDOG:   HRDATA[WDOG_W-1:0] <= watchdog_counter;
          cix_pkg::A_HEAD:   HRDATA[cix_pkg::PC_W-1:0] <= stack_head;
          default:           HRDATA[0] <= 1'b0;
        endcase
      end
    end
  end

  // no wait states are ever inserted
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
    end else begin
      HREADYOUT <= 1'b1;
    end
  end

  // every transfer ends okay, unmapped ones included
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      HRESP <= 1'b0;
    end else begin
      HRESP <= 1'b0;
    end
  end
endmodule

// ===== hw/cix_pkg.sv
// Purpose: constants, fields and opcodes for the instruction subset executor
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes: bus map and opcode values are local to this block
package cix_pkg;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int K_W = 11;
  localparam int F_W = 7;
  localparam int B_W = 3;
  localparam int LATCH_W = 5;
  localparam int ADDR_W = 12;
  // instruction fields and upper pc latch bits
  localparam int OP_LSB = 11;
  localparam int D_BIT = 7;
  localparam int B_LSB = 7;
  localparam int PCL_HI = 4;
  localparam int PCL_LO = 3;
  // status bit positions
  localparam int ST_Z = 0;
  localparam int ST_SLEEP_N = 1;
  localparam int ST_EXPIRY_N = 2;
  // register byte offsets
  localparam logic [ADDR_W-1:0] A_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] A_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] A_PC = 12'h008;
  localparam logic [ADDR_W-1:0] A_ACC = 12'h00C;
  localparam logic [ADDR_W-1:0] A_LATCH = 12'h010;
  localparam logic [ADDR_W-1:0] A_WDOG = 12'h014;
  localparam logic [ADDR_W-1:0] A_HEAD = 12'h018;
  localparam logic [1:0] WIN_RF = 2'h1;
  localparam logic [1:0] WIN_PM = 2'h2;
  localparam int WIN_LSB = 10;
  localparam int WIN_MSB = 11;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [PC_W-1:0] PC_TWO = 13'h0002;
  typedef enum logic [2:0] {
    OP_NOP, OP_SKIP_ON_BIT_LOW, OP_CALL, OP_KICK_WATCHDOG,
    OP_ZERO_FILE_REG, OP_INVERT_FILE_REG, OP_ZERO_ACCUMULATOR, OP_REDUCE_BY_ONE
  } cix_op_t;
endpackage

// ===== hw/cix_wdog.sv
// Purpose: watchdog counter with prescaler
// Assumes: prescaler counts every system clock, counter once per 2**PRE_W clocks
// Notes: expiry has no effect here, the counter only wraps
`timescale 1ns/100ps
module cix_wdog #(
  parameter int PRE_W = 8, // prescaler width
  parameter int CNT_W = 8  // counter width
) (
  input  wire logic             clk,   // system clock
  input  wire logic             rst,   // sync reset, high
  input  wire logic             clear, // kick pulse
  output logic      [CNT_W-1:0] count  // watchdog counter
);
  logic [PRE_W-1:0] pre;

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      pre <= '0;
    end else begin
      pre <= pre + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count <= '0;
    end else if (&pre) begin
      count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ===== tb/cix_core_chk.sv
// Purpose: bus-side assertions for the instruction subset executor
// Assumes: sees only the top module ports
// Notes: core state is visible only through register reads
`timescale 1ns/100ps
module cix_core_chk (
  input wire logic        CLK_SYS,   // system clock
  input wire logic        RST,       // sync reset
  input wire logic        HSEL,      // select
  input wire logic [31:0] HADDR,     // address
  input wire logic [1:0]  HTRANS,    // transfer type
  input wire logic        HWRITE,    // direction
  input wire logic        HREADY,    // bus ready
  input wire logic [31:0] HRDATA,    // read data
  input wire logic        HREADYOUT, // slave ready
  input wire logic        HRESP      // response
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic rd;
  assign rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
  sequence s_rd(logic [11:0] a);
    rd && HADDR[11:0] == a;
  endsequence
  sequence s_rd_gap;
    rd && (HADDR[11:10] == 2'h3 || HADDR[11:9] == 3'h3 ||
           (HADDR[11:10] == 2'h0 && HADDR[9:0] >= 10'h01C));
  endsequence
  a_ready_high: assert property (HREADYOUT) else $error("slave stalled");
  a_resp_okay: assert property (!HRESP) else $error("error response");
  a_rdata_stands: assert property (!$past(rd) |-> $stable(HRDATA))
    else $error("read data moved without a read");
  a_gap_zero: assert property (s_rd_gap |=> HRDATA == 32'h00000000)
    else $error("unmapped read not zero");
  a_status_width: assert property (s_rd(cix_pkg::A_STATUS) |=> HRDATA[31:3] == 29'h0)
    else $error("status upper bits set");
  a_acc_width: assert property (s_rd(cix_pkg::A_ACC) |=> HRDATA[31:8] == 24'h0)
    else $error("accumulator upper bits set");
  a_pc_width: assert property (s_rd(cix_pkg::A_PC) |=> HRDATA[31:13] == 19'h0)
    else $error("pc upper bits set");
  a_head_width: assert property (s_rd(cix_pkg::A_HEAD) |=> HRDATA[31:13] == 19'h0)
    else $error("stack head upper bits set");
  a_file_width: assert property (rd && HADDR[11:9] == 3'h2 |=> HRDATA[31:8] == 24'h0)
    else $error("file register upper bits set");
endmodule
bind cix_core cix_core_chk u_cix_core_chk (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP));

// ===== tb/cix_host.sv
// Purpose: AHB-Lite master model, single word transfers
// Assumes: one slave, its ready fed back as hready
// Notes: waits on hready, never on a cycle count
`timescale 1ns/100ps
module cix_host (
  input  wire logic        clk,    // system clock
  input  wire logic        hready, // bus ready
  input  wire logic [31:0] hrdata, // read data
  output logic             hsel,   // slave select
  output logic      [31:0] haddr,  // byte address
  output logic      [1:0]  htrans, // transfer type
  output logic             hwrite, // write when high
  output logic      [2:0]  hsize,  // always word
  output logic      [31:0] hwdata  // write data
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // idle data lines toggle so a stale value never looks valid
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

// ===== tb/testbench.sv
// Purpose: runs short programs and checks results over the bus
// Assumes: prescaler shortened to 2 bits, program ends in a call to itself
// Notes: no completion flag exists, so runs last a fixed span
`timescale 1ns/100ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          miscompares = 0;
  int          checked = 0;
  always #5 clk_sys = ~clk_sys;
  cix_host host (.clk(clk_sys), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  cix_core #(.PRE_W(2)) u_cix_core (.CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp));
  task automatic end_of_test;
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    host.xfer(1'b1, a, d, rv);
  endtask
  task automatic rc(string n, logic [11:0] a, logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rv);
    chk(n, rv, e);
  endtask
  function automatic logic [11:0] rf(logic [6:0] f);
    return 12'h400 + {3'h0, f, 2'h0};
  endfunction
  task automatic load(logic [13:0] p [], logic [12:0] latch);
    wr(cix_pkg::A_PC, 32'h0);
    wr(cix_pkg::A_LATCH, {19'h0, latch});
    foreach (p[i]) wr(12'h800 + 12'(i * 4), {18'h0, p[i]});
  endtask
  task automatic run;
    wr(cix_pkg::A_CTRL, 32'h1);
    repeat (60) @(posedge clk_sys);
    wr(cix_pkg::A_CTRL, 32'h0);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    rc("status", cix_pkg::A_STATUS, 32'h6);
    rc("acc", cix_pkg::A_ACC, 32'h0);
    rc("pc", cix_pkg::A_PC, 32'h0);
    rc("gap", 12'h01C, 32'h0);
    rc("gap_mid", 12'h600, 32'h0);
    rc("gap_hi", 12'hC00, 32'h0);
  endtask
  // skips, file ops, wrap into accumulator, kick, self call with upper latch
  task automatic t_flow;
    logic [13:0] p [] = '{14'h0990, 14'h2891, 14'h0910, 14'h2018, 14'h3892,
                          14'h2016, 14'h3817, 14'h1800, 14'h1708};
    wr(rf(7'h10), 32'h08);
    wr(rf(7'h11), 32'h3C);
    wr(rf(7'h12), 32'h05);
    wr(rf(7'h16), 32'h77);
    wr(rf(7'h17), 32'h00);
    wr(rf(7'h18), 32'h99);
    wr(cix_pkg::A_ACC, 32'h55);
    // flags start low so the kick has something to set
    wr(cix_pkg::A_STATUS, 32'h0);
    load(p, 13'h18);
    // let the watchdog climb well above what a kicked one reaches
    repeat (400) @(posedge clk_sys);
    run();
    host.xfer(1'b0, cix_pkg::A_WDOG, 32'h0, rv);
    chk("wdog", {31'h0, rv < 32'h20}, 32'h1);
    rc("not_skipped", rf(7'h11), 32'hC3);
    rc("skipped", rf(7'h18), 32'h99);
    rc("zero_file", rf(7'h16), 32'h00);
    rc("reduce_file", rf(7'h12), 32'h04);
    rc("reduce_keep", rf(7'h17), 32'h00);
    rc("wrap_acc", cix_pkg::A_ACC, 32'hFF);
    rc("flags_a", cix_pkg::A_STATUS, 32'h6);
    rc("call_pc", cix_pkg::A_PC, 32'h1F08);
    rc("call_head", cix_pkg::A_HEAD, 32'h1F09);
  endtask
  task automatic t_acc;
    logic [13:0] p [] = '{14'h2813, 14'h1001};
    logic [13:0] q [] = '{14'h3000, 14'h1001};
    wr(rf(7'h13), 32'h5A);
    wr(cix_pkg::A_STATUS, 32'h1);
    load(p, 13'h00);
    run();
    rc("invert_keep", rf(7'h13), 32'h5A);
    rc("invert_acc", cix_pkg::A_ACC, 32'hA5);
    rc("flags_inv", cix_pkg::A_STATUS, 32'h0);
    load(q, 13'h00);
    run();
    rc("zero_acc", cix_pkg::A_ACC, 32'h00);
    rc("flags_b", cix_pkg::A_STATUS, 32'h1);
    rc("call_pc_b", cix_pkg::A_PC, 32'h0001);
    rc("call_head_b", cix_pkg::A_HEAD, 32'h0002);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_flow();
    t_acc();
    end_of_test();
  end
  // the whole sequence needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    end_of_test();
  end
endmodule
